// ### rtl/gated_pulse_counter_io.sv
/*
 * Top of the three-channel gated pulse counter with the on-board digital
 * input and output image, reached over an APB slave.
 * Assumes 24 V inputs arrive level-shifted and asynchronous to ref_clk.
 */
// How it works
// - Three channels; continuous, single and periodic counting.
// - Count pulses must hold each level 0.1 ms or more to pass the input filter; about 5 kHz at most.
// - Internal gate combines hardware and software gate; hardware evaluation can be off.
// - Gate pin rising edge opens the hardware gate.
// - Gate pin falling edge closes the hardware gate.
// - Each count is one 32-bit word at 0x300, 0x304, 0x308.
// - Counter inputs stay readable; counter-owned outputs ignore image writes.
// - Single and periodic modes use end value upward, start value downward.
// - Each eligible input may interrupt on rising or falling edge.
// - Third input byte never raises interrupts.
// - Only diagnostic cause is a lost hardware interrupt.
// - Debounce per four inputs; 0.1 ms setting, else 0.35 ms.
// - Output indicators follow outputs; fault indicator shows overload.
// - Input bytes at 124..126; both output bytes written at 124 as one 16-bit word.
// - Counts readable at their own words 0x300..0x308, not at their input addresses.
// - Latch pin rising edge captures count into a holding register.
`timescale 1ns/1ps
module gated_pulse_counter_io
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output      logic [31:0]       prdata,
	output      logic              pready,
	output      logic              pslverr,
	// Field pins
	input  wire logic [NUM_DI-1:0] di_pin,
	input  wire logic              out_fault_pin,
	output      logic [NUM_DO-1:0] do_pin,
	output      logic [NUM_DO-1:0] do_led,
	output      logic              fault_led,
	// Interrupt
	output      logic              irq
);

	// ************************************************************
	// Registers
	// ************************************************************
	logic [NUM_DO-1:0]  out_img_r;
	logic [15:0]        ctrl_r;
	logic [5:0]         mode_r;
	logic [31:0]        limit_r [NUM_CH];
	logic [NUM_IRQ-1:0] irq_rise_r;
	logic [NUM_IRQ-1:0] irq_fall_r;
	logic [5:0]         deb_r;
	logic [16:0]        stat_r;
	logic [16:0]        ien_r;
	logic [NUM_DI-1:0]  di_level;
	logic [NUM_DI-1:0]  di_prev_r;
	logic [31:0]        count_w [NUM_CH];
	logic [31:0]        latch_w [NUM_CH];
	logic [NUM_CH-1:0]  hardware_gate_w;
	logic [NUM_CH-1:0]  wrap_w;
	logic [31:0]        rdata;
	logic               rd_err;
	logic               wr_en;
	logic [16:0]        events;
	logic [16:0]        clr;
	logic [NUM_DO-1:0]  do_nxt;

	localparam logic [DEB_CNT_W-1:0] DEB_SHORT = DEB_CNT_W'(DEB_SHORT_CYC);
	localparam logic [DEB_CNT_W-1:0] DEB_LONG  = DEB_CNT_W'(DEB_LONG_CYC);

	assign wr_en = psel & penable & pwrite;

	// ************************************************************
	// Input filtering
	// ************************************************************
	// Each group of four inputs shares one delay code; zero means 0.1 ms.
	for (genvar i = 0; i < NUM_DI; i++) begin : g_filt
		input_filter u_filt (
			.ref_clk  (ref_clk),
			.rst_n    (rst_n),
			.pin      (di_pin[i]),
			.delay_cyc(deb_r[i/4] ? DEB_LONG : DEB_SHORT),
			.level    (di_level[i])
		);
	end

	// ************************************************************
	// Counter channels
	// ************************************************************
	// Pin roles: pulse I0.0/0.3/0.6, gate I0.2/0.5/1.0, latch I1.4..1.6.
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		cnt_cfg_s  cfg;
		cnt_pins_s pins;
		assign cfg.gate_sw    = ctrl_r[CTRL_SWG_LSB + c];
		assign cfg.gate_hw_en = ctrl_r[CTRL_HWEN_LSB + c];
		assign cfg.down       = ctrl_r[CTRL_DIR_LSB + c];
		assign cfg.abort      = ctrl_r[CTRL_ABORT_LSB + c];
		assign cfg.mode       = cnt_mode_e'(mode_r[2*c +: 2]);
		assign cfg.limit      = limit_r[c];
		assign pins.pulse     = di_level[3*c];
		assign pins.gate      = di_level[3*c + 2];
		assign pins.latch     = di_level[12 + c];
		count_channel u_ch (
			.ref_clk  (ref_clk),
			.rst_n    (rst_n),
			.cfg      (cfg),
			.pins     (pins),
			.count_r  (count_w[c]),
			.latch_r  (latch_w[c]),
			.hardware_gate_r(hardware_gate_w[c]),
			.wrap_r   (wrap_w[c])
		);
	end

	// ************************************************************
	// Configuration writes
	// ************************************************************
	// Writes land at the access phase; the slave answers with no wait.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_img_r  <= '0;
			ctrl_r     <= 16'h0;
			mode_r     <= 6'h0;
			irq_rise_r <= '0;
			irq_fall_r <= '0;
			deb_r      <= DEB_RST;
			ien_r      <= '0;
			for (int k = 0; k < NUM_CH; k++) begin
				limit_r[k] <= LIMIT_RST;
			end
		end else if (wr_en) begin
			case (paddr)
				ADDR_DI0:      out_img_r <= pwdata[15:0];
				ADDR_CTRL:     ctrl_r <= pwdata[15:0];
				ADDR_MODE:     mode_r <= pwdata[5:0];
				ADDR_IRQ_RISE: irq_rise_r <= pwdata[NUM_IRQ-1:0];
				ADDR_IRQ_FALL: irq_fall_r <= pwdata[NUM_IRQ-1:0];
				ADDR_DEB:      deb_r <= pwdata[5:0];
				ADDR_IEN:      ien_r <= pwdata[16:0];
				default: begin
					for (int k = 0; k < NUM_CH; k++) begin
						if (paddr == ADDR_LIMIT0 + 12'(4 * k)) begin
							limit_r[k] <= pwdata;
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	// Input byte 2 is never wired to an event.
	always_comb begin
		events = '0;
		for (int k = 0; k < NUM_IRQ; k++) begin
			events[k] = (irq_rise_r[k] & di_level[k] & ~di_prev_r[k]) |
				(irq_fall_r[k] & ~di_level[k] & di_prev_r[k]);
		end
		// A second event on a still-pending bit counts as lost.
		events[STAT_LOST] = |(events[NUM_IRQ-1:0] & stat_r[NUM_IRQ-1:0]);
		clr = (wr_en && paddr == ADDR_CLR) ? pwdata[16:0] : 17'h0;
	end

	// Sticky status; a new event wins over a simultaneous clear.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			di_prev_r <= '0;
			stat_r    <= '0;
			irq       <= 1'b0;
		end else begin
			di_prev_r <= di_level;
			stat_r    <= (stat_r & ~clr) | events;
			irq       <= |(((stat_r & ~clr) | events) & ien_r);
		end
	end

	// ************************************************************
	// Outputs and indicators
	// ************************************************************
	// Bits 0..2 are the channel outputs; their image writes are ignored
	// while the channel owns them, and comparison is not modelled here.
	always_comb begin
		do_nxt = out_img_r;
		for (int k = 0; k < NUM_CH; k++) begin
			if (mode_r[2*k +: 2] != 2'b10 && ctrl_r[CTRL_SWG_LSB + k]) begin
				do_nxt[k] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			do_pin    <= '0;
			do_led    <= '0;
			fault_led <= 1'b0;
		end else begin
			do_pin    <= do_nxt;
			do_led    <= do_nxt;
			fault_led <= out_fault_pin;
		end
	end

	// ************************************************************
	// APB read path
	// ************************************************************
	// Counter-owned inputs are read back like any other input.
	always_comb begin
		rdata  = 32'h0;
		rd_err = 1'b0;
		case (paddr)
			ADDR_DI0:      rdata = {24'h0, di_level[7:0]};
			ADDR_DI1:      rdata = {24'h0, di_level[15:8]};
			ADDR_DI2:      rdata = {24'h0, di_level[23:16]};
			ADDR_CNT0:     rdata = count_w[0];
			ADDR_CNT1:     rdata = count_w[1];
			ADDR_CNT2:     rdata = count_w[2];
			ADDR_SPARE:    rdata = 32'h0;
			ADDR_CTRL:     rdata = {16'h0, ctrl_r};
			ADDR_MODE:     rdata = {26'h0, mode_r};
			ADDR_IRQ_RISE: rdata = {16'h0, irq_rise_r};
			ADDR_IRQ_FALL: rdata = {16'h0, irq_fall_r};
			ADDR_DEB:      rdata = {26'h0, deb_r};
			ADDR_STAT:     rdata = {15'h0, stat_r};
			ADDR_CLR:      rdata = 32'h0;
			ADDR_IEN:      rdata = {15'h0, ien_r};
			ADDR_FAULT:    rdata = {25'h0, wrap_w, 1'b0, hardware_gate_w};
			default: begin
				rd_err = 1'b1;
				for (int k = 0; k < NUM_CH; k++) begin
					if (paddr == ADDR_LIMIT0 + 12'(4 * k)) begin
						rdata  = limit_r[k];
						rd_err = 1'b0;
					end
					if (paddr == ADDR_LATCH0 + 12'(4 * k)) begin
						rdata  = latch_w[k];
						rd_err = 1'b0;
					end
				end
			end
		endcase
	end

	// Answer registered: pready rises together with penable, in the first access cycle.
	// Single-word accesses need no job queue; completion is pready.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= rdata;
			pslverr <= psel & ~penable & rd_err;
		end
	end

endmodule : gated_pulse_counter_io

// ### rtl/gpc_pkg.sv
/*
 * Shared constants and carrier types for the gated pulse counter and
 * digital I/O image block.
 * Assumes a 100 MHz ref_clk and an APB slave with 32-bit data.
 */
package gpc_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned MAX_COUNT_KHZ   = 30;
	localparam int unsigned DEB_SHORT_NS    = 100000;	// 0.1 ms
	localparam int unsigned DEB_LONG_NS     = 350000;	// 0.35 ms
	localparam int unsigned DEB_SHORT_CYC   = DEB_SHORT_NS * CLK_MHZ / 1000;
	localparam int unsigned DEB_LONG_CYC    = DEB_LONG_NS * CLK_MHZ / 1000;
	localparam int unsigned DEB_CNT_W       = 16;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int unsigned NUM_CH  = 3;
	localparam int unsigned NUM_DI  = 24;
	localparam int unsigned NUM_DO  = 16;
	localparam int unsigned NUM_IRQ = 16;	// Only the first two input bytes.

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [11:0] ADDR_DI0      = 12'h07c;	// Also output byte 0.
	localparam logic [11:0] ADDR_DI1      = 12'h07d;
	localparam logic [11:0] ADDR_DI2      = 12'h07e;
	localparam logic [11:0] ADDR_CNT0     = 12'h300;
	localparam logic [11:0] ADDR_CNT1     = 12'h304;
	localparam logic [11:0] ADDR_CNT2     = 12'h308;
	localparam logic [11:0] ADDR_SPARE    = 12'h30c;
	localparam logic [11:0] ADDR_CTRL     = 12'h400;
	localparam logic [11:0] ADDR_MODE     = 12'h404;
	localparam logic [11:0] ADDR_LIMIT0   = 12'h410;
	localparam logic [11:0] ADDR_LATCH0   = 12'h420;
	localparam logic [11:0] ADDR_IRQ_RISE = 12'h430;
	localparam logic [11:0] ADDR_IRQ_FALL = 12'h434;
	localparam logic [11:0] ADDR_DEB      = 12'h438;
	localparam logic [11:0] ADDR_STAT     = 12'h440;
	localparam logic [11:0] ADDR_CLR      = 12'h444;
	localparam logic [11:0] ADDR_IEN      = 12'h448;
	localparam logic [11:0] ADDR_FAULT    = 12'h44c;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int unsigned CTRL_SWG_LSB  = 0;	// Software gates, bits 2:0.
	localparam int unsigned CTRL_HWEN_LSB = 4;	// Hardware gate evaluation, 6:4.
	localparam int unsigned CTRL_DIR_LSB  = 8;	// 1 counts down, 10:8.
	localparam int unsigned CTRL_ABORT_LSB = 12;	// Gate opens reload, 14:12.
	localparam int unsigned STAT_LOST     = 16;	// Lost interrupt bit.
	localparam logic [31:0] LIMIT_RST     = 32'h7fffffff;
	localparam logic [5:0]  DEB_RST       = 6'h00;	// 0 selects 0.1 ms.

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_CONT   = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_PERIOD = 2'b11
	} cnt_mode_e;

	typedef struct packed {
		logic      gate_sw;
		logic      gate_hw_en;
		logic      down;
		logic      abort;
		cnt_mode_e mode;
		logic [31:0] limit;
	} cnt_cfg_s;

	typedef struct packed {
		logic pulse;
		logic gate;
		logic latch;
	} cnt_pins_s;

endpackage : gpc_pkg

// ### rtl/input_filter.sv
/*
 * One debounced input: three-flop synchroniser, then a stability timer.
 * Assumes the input is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
module input_filter
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Pin and setting
	input  wire logic                 pin,
	input  wire logic [DEB_CNT_W-1:0] delay_cyc,
	// Filtered level
	output      logic                 level
);

	logic [2:0]           sync_r;
	logic [DEB_CNT_W-1:0] cnt_r;

	// Synchroniser; only bits 2 and 1 are ever compared.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= 3'h0;
		end else begin
			sync_r <= {sync_r[1:0], pin};
		end
	end

	// A level change is accepted only after it stayed stable for the delay.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			level <= 1'b0;
		end else if (sync_r[2] != sync_r[1] || sync_r[2] == level) begin
			cnt_r <= '0;
		end else if (cnt_r >= delay_cyc) begin
			level <= sync_r[2];
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

endmodule : input_filter

// ### rtl/count_channel.sv
/*
 * One counter channel: gate logic, three counting modes and a latch.
 * Assumes filtered, synchronous pins from the parent.
 */
`timescale 1ns/1ps
module count_channel
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Setup and pins
	input  wire cnt_cfg_s    cfg,
	input  wire cnt_pins_s   pins,
	// Results
	output      logic [31:0] count_r,
	output      logic [31:0] latch_r,
	output      logic        hardware_gate_r,
	output      logic        wrap_r
);

	logic pulse_d_r;
	logic gate_d_r;
	logic latch_d_r;
	logic igate;
	logic igate_d_r;
	logic done_r;
	logic step;

	// Hardware gate opens on 0-1 and closes on 1-0 of the gate pin.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_d_r  <= 1'b0;
			hardware_gate_r <= 1'b0;
		end else begin
			gate_d_r <= pins.gate;
			if (pins.gate && !gate_d_r) begin
				hardware_gate_r <= 1'b1;
			end else if (!pins.gate && gate_d_r) begin
				hardware_gate_r <= 1'b0;
			end
		end
	end

	// Bypassed hardware gate counts as open.
	assign igate = cfg.gate_sw & (hardware_gate_r | ~cfg.gate_hw_en);
	// Pins are filtered for 0.1 ms at least, so 30 kHz edges do not pass.
	assign step  = igate & pins.pulse & ~pulse_d_r & ~done_r;

	// Counting; opening the gate in abort mode reloads the start point.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_d_r <= 1'b0;
			igate_d_r <= 1'b0;
			count_r   <= 32'h0;
			done_r    <= 1'b0;
			wrap_r    <= 1'b0;
		end else begin
			pulse_d_r <= pins.pulse;
			igate_d_r <= igate;
			wrap_r    <= 1'b0;
			if (igate && !igate_d_r && cfg.abort) begin
				count_r <= cfg.down ? cfg.limit : 32'h0;
				done_r  <= 1'b0;
			end else if (step) begin
				if (cfg.mode == MODE_CONT) begin
					count_r <= cfg.down ? count_r - 1'b1 : count_r + 1'b1;
				end else if (!cfg.down && count_r == cfg.limit - 1'b1) begin
					count_r <= 32'h0;
					wrap_r  <= 1'b1;
					done_r  <= (cfg.mode == MODE_SINGLE);
				end else if (cfg.down && count_r <= 32'h1) begin
					count_r <= cfg.limit;
					wrap_r  <= 1'b1;
					done_r  <= (cfg.mode == MODE_SINGLE);
				end else begin
					count_r <= cfg.down ? count_r - 1'b1 : count_r + 1'b1;
				end
			end
		end
	end

	// Latch pin 0-1 captures the live count.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_d_r <= 1'b0;
			latch_r   <= 32'h0;
		end else begin
			latch_d_r <= pins.latch;
			if (pins.latch && !latch_d_r) begin
				latch_r <= count_r;
			end
		end
	end

endmodule : count_channel

// ### testbench/gpc_chk.sv
/*
 * Port assertions for the gated pulse counter block.
 * Assumes one clock domain and the 0.1 ms input filter setting.
 */
`timescale 1ns/1ps
module gpc_chk
	import gpc_pkg::*;
(
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_n,
	// APB
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Field pins
	input wire logic [NUM_DI-1:0] di_pin,
	input wire logic              out_fault_pin,
	input wire logic [NUM_DO-1:0] do_pin,
	input wire logic [NUM_DO-1:0] do_led,
	input wire logic              fault_led,
	input wire logic              irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic              setup;
	logic              wr_any;
	logic [15:0]       quiet_r;
	logic [NUM_DI-1:0] di_prev_r;

	// ************************************************************
	// Helpers
	// ************************************************************
	assign setup  = psel && !penable;
	assign wr_any = psel && pwrite;

	// Cycles since any input pin last moved, saturating so it never wraps.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet_r   <= '0;
			di_prev_r <= '0;
		end else begin
			di_prev_r <= di_pin;
			if (di_pin != di_prev_r) quiet_r <= '0;
			else if (quiet_r != 16'hffff) quiet_r <= quiet_r + 16'h1;
		end
	end

	// ************************************************************
	// Properties
	// ************************************************************
	property p_ready; setup |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no answer after setup");
	property p_single; pready |=> !pready; endproperty
	a_single: assert property (p_single) else $error("answer held too long");
	property p_spare; setup && !pwrite && paddr == ADDR_SPARE |=> prdata == 32'h0 && !pslverr;
	endproperty
	a_spare: assert property (p_spare) else $error("spare word not zero");
	property p_unmap; setup && paddr == 12'h200 |=> pready && pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_di2; setup && !pwrite && paddr == ADDR_DI2 |=> prdata[31:8] == 24'h0;
	endproperty
	a_di2: assert property (p_di2) else $error("input byte two too wide");
	property p_dowr;
		psel && penable && pwrite && paddr == ADDR_DI0 |=> ##1 do_pin[15:3] == $past(pwdata[15:3], 2);
	endproperty
	a_dowr: assert property (p_dowr) else $error("output image write lost");
	property p_led; $changed(do_pin) |-> ##[0:1] (do_led == do_pin); endproperty
	a_led: assert property (p_led) else $error("indicator not following output");
	property p_fault; fault_led == $past(out_fault_pin); endproperty
	a_fault: assert property (p_fault) else $error("fault indicator wrong");
	property p_irqfall;
		$fell(irq) |-> $past(wr_any, 1) || $past(wr_any, 2) || $past(wr_any, 3);
	endproperty
	a_irqfall: assert property (p_irqfall) else $error("interrupt dropped unasked");
	property p_deb; $rose(irq) |-> quiet_r >= 16'd10000; endproperty
	a_deb: assert property (p_deb) else $error("input edge seen before filter time");

	c_irq: cover property ($rose(irq));
	c_err: cover property (pready && pslverr);
	c_cnt: cover property (setup && paddr == ADDR_CNT0);
endmodule : gpc_chk

bind gated_pulse_counter_io gpc_chk chk_u (.ref_clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .di_pin, .out_fault_pin, .do_pin,
	.do_led, .fault_led, .irq);

// ### testbench/field_src.sv
/*
 * Field pin model that drives the raw field inputs and the overload report.
 * Assumes the caller spaces changes of a pin just beyond the input filter time.
 */
`timescale 1ns/1ps
module field_src (
	// Clock
	input wire logic  ref_clk,
	// Field pins toward the block
	output logic [23:0] di_pin,
	output logic        out_fault_pin
);
	// Push-pull 24 V drivers: lines are always driven, idle low.
	initial begin
		di_pin        = '0;
		out_fault_pin = 1'b0;
	end

	// Moves the masked pins together, just after a clock edge.
	task automatic set_pins(input logic [23:0] mask, input logic v);
		@(posedge ref_clk);
		di_pin <= v ? (di_pin | mask) : (di_pin & ~mask);
	endtask : set_pins

	// Overload report of the output driver stage.
	task automatic set_fault(input logic v);
		@(posedge ref_clk);
		out_fault_pin <= v;
	endtask : set_fault
endmodule : field_src

// ### testbench/tb.sv
/*
 * Self-checking bench for the gated pulse counter and I/O image block.
 * Assumes the default 0.1 ms filter, so every pin change takes 10000 cycles.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb
	import gpc_pkg::*;
;
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, out_fault_pin, fault_led, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [23:0] di_pin;
	logic [15:0] do_pin, do_led;
	int          mismatches, check_count;

	field_src src_u (.ref_clk, .di_pin, .out_fault_pin);
	gated_pulse_counter_io dut_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .di_pin, .out_fault_pin, .do_pin, .do_led,
		.fault_led, .irq);

	// ************************************************************
	// Clock, bus tasks and closing
	// ************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
	endtask : wreg

	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm,
		input logic [31:0] msk = 32'hffffffff);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		`CHK(nm, e, rd & msk)
	endtask : rchk

	// Wait out the filter; the spacing also keeps pulses far below 30 kHz.
	task automatic settle();
		repeat (DEB_SHORT_CYC + 10) @(posedge ref_clk);
	endtask : settle

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic s_regs();
		logic [31:0] rd;
		logic        err;
		rchk(ADDR_CNT0, 32'h0, "count0 reset");
		rchk(ADDR_LIMIT0, LIMIT_RST, "limit0 reset");
		rchk(ADDR_SPARE, 32'h0, "spare word");
		apb(1'b0, 12'h200, 32'h0, rd, err);
		`CHK("unmapped error", 1'b1, err)
	endtask : s_regs

	task automatic s_out();
		wreg(ADDR_DI0, 32'ha5c3);
		src_u.set_fault(1'b1);
		repeat (2) @(posedge ref_clk);
		`CHK("output image", 16'ha5c3, do_pin)
		`CHK("output leds", 16'ha5c3, do_led)
		`CHK("fault led", 1'b1, fault_led)
		src_u.set_fault(1'b0);
	endtask : s_out

	task automatic s_count();
		wreg(ADDR_IRQ_RISE, 32'h1);
		wreg(ADDR_IEN, 32'h1);
		wreg(ADDR_CTRL, 32'h1);
		src_u.set_pins(24'hff0001, 1'b1);
		settle();
		rchk(ADDR_CNT0, 32'h1, "count0 one pulse");
		rchk(ADDR_DI0, 32'h1, "input byte0", 32'hff);
		rchk(ADDR_DI2, 32'hff, "input byte2");
		`CHK("irq raised", 1'b1, irq)
		rchk(ADDR_STAT, 32'h1, "status");
		wreg(ADDR_CLR, 32'h1);
		repeat (3) @(posedge ref_clk);
		`CHK("irq cleared", 1'b0, irq)
		rchk(ADDR_STAT, 32'h0, "status cleared");
		wreg(ADDR_DI0, 32'hffff);
		repeat (2) @(posedge ref_clk);
		`CHK("counter output kept", 16'hfffe, do_pin)
	endtask : s_count

	task automatic s_gate();
		wreg(ADDR_IEN, 32'h0);
		// Channel 1 periodic up to end value 2, channel 2 single down from 3.
		wreg(ADDR_MODE, 32'h1c);
		wreg(ADDR_LIMIT0 + 12'h004, 32'h2);
		wreg(ADDR_LIMIT0 + 12'h008, 32'h3);
		wreg(ADDR_CTRL, 32'h417);
		src_u.set_pins(24'h49, 1'b0);
		settle();
		src_u.set_pins(24'h49, 1'b1);
		settle();
		rchk(ADDR_CNT0, 32'h1, "count0 gate shut");
		rchk(ADDR_CNT1, 32'h1, "count1 periodic first");
		rchk(ADDR_CNT2, 32'h3, "count2 down reload");
		rchk(ADDR_STAT, 32'h1, "status masked", 32'h1);
		`CHK("irq masked", 1'b0, irq)
		src_u.set_pins(24'h4, 1'b1);
		settle();
		rchk(ADDR_FAULT, 32'h1, "hardware_gate open", 32'h7);
		src_u.set_pins(24'h49, 1'b0);
		settle();
		src_u.set_pins(24'h49, 1'b1);
		settle();
		rchk(ADDR_CNT0, 32'h2, "count0 gate open");
		rchk(ADDR_CNT1, 32'h0, "count1 periodic wrap");
		rchk(ADDR_CNT2, 32'h3, "count2 single stopped");
		src_u.set_pins(24'h1000, 1'b1);
		src_u.set_pins(24'h4, 1'b0);
		settle();
		rchk(ADDR_FAULT, 32'h0, "hardware_gate shut", 32'h7);
		rchk(ADDR_LATCH0, 32'h2, "latch0");
	endtask : s_gate

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		mismatches = 0; check_count = 0;
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		s_regs();
		s_out();
		s_count();
		s_gate();
		end_sim();
	end

	initial begin
		repeat (85000) @(posedge ref_clk);
		mismatches++;
		end_sim();
	end
endmodule : tb
